// ---- verilog/bit_skip_pkg.sv ----
package bit_skip_pkg;

  // Address widths
  localparam int BANK_W = 4;
  localparam int ADDR_W = BANK_W + 8;

  // Opcode values in the top four bits
  localparam logic [3:0] OPC_SKIP_SET = 4'hA;
  localparam logic [3:0] OPC_SKIP_CLR = 4'hB;

  // Field positions within the instruction word
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int BIT_MSB = 11;
  localparam int BIT_LSB = 9;
  localparam int BANK_SEL_POS = 8;
  localparam int FADDR_MSB = 7;

  // Access bank split and literal offset window
  localparam logic [7:0] LIT_OFFSET_MAX = 8'h5F;
  localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;

  // Phase positions in the one-hot phase vector
  localparam int PH_Q1 = 0;
  localparam int PH_Q2 = 1;
  localparam int PH_Q3 = 2;
  localparam int PH_Q4 = 3;
  localparam int PHASES = 4;
  localparam logic [PHASES-1:0] PHASE_RESET = 4'h1;

  // Skipped instruction length limits, in words
  localparam logic [1:0] MIN_SKIP_WORDS = 2'h1;

  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_TEST  = 3'b010,
    ST_IDLE  = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic [2:0] bit_idx;
    logic bank_sel;
    logic [7:0] faddr;
  } instr_fields_t;

  typedef struct packed {
    logic indexed;
    logic [ADDR_W-1:0] addr;
  } file_req_t;

endpackage

// ---- verilog/q_phase_gen.sv ----
module q_phase_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // One-hot phase, bit 0 is the first phase
  output logic [bit_skip_pkg::PHASES-1:0] phase
);
  import bit_skip_pkg::*;

  logic [PHASES-1:0] phase_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= PHASE_RESET;
    end else begin
      phase_ff <= {phase_ff[PHASES-2:0], phase_ff[PHASES-1]};
    end
  end

  assign phase = phase_ff;

endmodule

// ---- verilog/bit_skip_exec.sv ----
// Summary of operation
// - Top nibble 1010 with bit, bank and address fields means skip-when-set.
// - Skip-when-set skips next instruction only if tested bit is 1.
// - Taken skip flushes the prefetched word and runs an idle cycle.
// - Skip over two or three words lasts three or four cycles.
// - Bank bit 0 selects access bank; 1 uses the bank pointer.
// - First cycle decodes, reads, processes, no write; idle cycles do nothing.
// - Skip over a three-word instruction adds three full idle cycles.
// - Top nibble 1011 with the same fields means skip-when-clear.
// - Skip-when-clear skips only if tested bit is 0, same idling.
// - Extended set, bank bit 0, address up to 95 uses indexed mode.
module bit_skip_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Instruction presented in the first phase
  input wire logic instr_valid,
  input wire bit_skip_pkg::instr_fields_t instr_word,
  input wire logic ext_set_en,
  input wire logic [bit_skip_pkg::BANK_W-1:0] bank_pointer_register,
  // File register read port
  output logic file_rd_en,
  output bit_skip_pkg::file_req_t file_req,
  input wire logic [7:0] file_rd_data,
  // Pipeline control
  input wire logic [1:0] next_words,
  output logic flush_prefetch,
  output logic nop_cycle,
  output logic busy,
  output logic skip_taken,
  output logic exec_done,
  output logic [bit_skip_pkg::PHASES-1:0] phase
);
  import bit_skip_pkg::*;

  seq_state_t state_ff;
  seq_state_t nxt_state;
  instr_fields_t fields_ff;
  file_req_t req_ff;
  file_req_t nxt_req;
  logic is_clr_ff;
  logic skip_ff;
  logic [1:0] words_ff;
  logic [1:0] idle_left_ff;
  logic [1:0] nxt_words;
  logic op_hit;
  logic take_instr;
  logic sel_bit;
  logic last_idle;

  ////////////////////////////////////////////////////////////////////////////
  // Phase generator

  q_phase_gen u_phase (
    .clk(clk),
    .arst_n(arst_n),
    .phase(phase)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode and address formation

  assign op_hit = (instr_word.opcode == OPC_SKIP_SET) ||
                  (instr_word.opcode == OPC_SKIP_CLR);
  assign take_instr = (state_ff == ST_READY) && phase[PH_Q1] &&
                      instr_valid && op_hit;

  always_comb begin
    nxt_req.indexed = 1'b0;
    nxt_req.addr = {bank_pointer_register, instr_word.faddr};
    if (!instr_word.bank_sel) begin
      if (instr_word.faddr <= LIT_OFFSET_MAX) begin
        // Indexed mode passes the raw offset; base is added downstream
        nxt_req.indexed = ext_set_en;
        nxt_req.addr = {ACCESS_LO_BANK, instr_word.faddr};
      end else begin
        nxt_req.addr = {ACCESS_HI_BANK, instr_word.faddr};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fields_ff <= '0;
      req_ff <= '0;
      is_clr_ff <= 1'b0;
    end else if (take_instr) begin
      fields_ff <= instr_word;
      req_ff <= nxt_req;
      is_clr_ff <= (instr_word.opcode == OPC_SKIP_CLR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skip decision

  assign sel_bit = file_rd_data[fields_ff.bit_idx];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skip_ff <= 1'b0;
    end else if (take_instr) begin
      skip_ff <= 1'b0;
    end else if ((state_ff == ST_TEST) && phase[PH_Q2]) begin
      // Sampled in the second phase so flush is ready well before Q4
      skip_ff <= sel_bit ^ is_clr_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // A length of zero cannot occur; treat it as one word to stay safe
  assign nxt_words = (next_words == 2'h0) ? MIN_SKIP_WORDS : next_words;
  assign last_idle = (idle_left_ff == 2'h1);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_READY: begin
        if (take_instr) begin
          nxt_state = ST_TEST;
        end
      end
      ST_TEST: begin
        if (phase[PH_Q4]) begin
          nxt_state = skip_ff ? ST_IDLE : ST_READY;
        end
      end
      ST_IDLE: begin
        if (phase[PH_Q4] && last_idle) begin
          nxt_state = ST_READY;
        end
      end
      default: begin
        nxt_state = ST_READY;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_READY;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      words_ff <= MIN_SKIP_WORDS;
      idle_left_ff <= 2'h0;
    end else if ((state_ff == ST_TEST) && phase[PH_Q4] && skip_ff) begin
      words_ff <= nxt_words;
      idle_left_ff <= nxt_words;
    end else if ((state_ff == ST_IDLE) && phase[PH_Q4]) begin
      idle_left_ff <= idle_left_ff - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // No write strobe exists: register and flags stay untouched
  assign file_rd_en = (state_ff == ST_TEST) && phase[PH_Q2];
  assign file_req = req_ff;
  assign flush_prefetch = (state_ff == ST_TEST) && phase[PH_Q4] &&
                          skip_ff;
  assign nop_cycle = (state_ff == ST_IDLE);
  assign busy = (state_ff != ST_READY);
  assign skip_taken = skip_ff;
  assign exec_done = phase[PH_Q4] &&
                     (((state_ff == ST_TEST) && !skip_ff) ||
                      ((state_ff == ST_IDLE) && last_idle));

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] nop_len_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nop_len_ff <= 4'h0;
    end else if (nop_cycle) begin
      nop_len_ff <= nop_len_ff + 4'h1;
    end else begin
      nop_len_ff <= 4'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_decode_set: assert property (
    take_instr && (instr_word.opcode == OPC_SKIP_SET)
    |=> (state_ff == ST_TEST) && !is_clr_ff)
    else $error("skip-when-set opcode not decoded");

  a_decode_clear: assert property (
    take_instr && (instr_word.opcode == OPC_SKIP_CLR)
    |=> (state_ff == ST_TEST) && is_clr_ff)
    else $error("skip-when-clear opcode not decoded");

  a_skip_when_set: assert property (
    (state_ff == ST_TEST) && phase[PH_Q2] && !is_clr_ff
    |=> skip_taken == $past(sel_bit))
    else $error("skip-when-set decision wrong");

  a_skip_when_clear: assert property (
    (state_ff == ST_TEST) && phase[PH_Q2] && is_clr_ff
    |=> skip_taken == !$past(sel_bit))
    else $error("skip-when-clear decision wrong");

  a_flush_then_idle: assert property (
    (state_ff == ST_TEST) && phase[PH_Q4] && skip_taken
    |-> flush_prefetch ##1 nop_cycle [*4])
    else $error("taken skip did not flush and idle");

  a_idle_length: assert property (
    $fell(nop_cycle) |-> nop_len_ff == {words_ff, 2'b00})
    else $error("idle time does not match skipped words");

  a_three_word_idle: assert property (
    $rose(nop_cycle) && (words_ff == 2'h3)
    |-> ##11 nop_cycle ##1 !nop_cycle)
    else $error("three-word skip idle length wrong");

  a_idle_does_nothing: assert property (
    nop_cycle |-> !file_rd_en && !flush_prefetch && !take_instr)
    else $error("activity during idle cycle");

  a_bank_pointer: assert property (
    take_instr && instr_word.bank_sel
    |=> file_req.addr == {$past(bank_pointer_register), fields_ff.faddr})
    else $error("banked address not from bank pointer");

  a_indexed_mode: assert property (
    take_instr |=> file_req.indexed == ($past(ext_set_en) &&
      !fields_ff.bank_sel && (fields_ff.faddr <= LIT_OFFSET_MAX)))
    else $error("indexed mode selection wrong");

  a_decide_in_q2: assert property (
    file_rd_en |-> ##2
      (flush_prefetch == ($past(sel_bit, 2) ^ is_clr_ff)))
    else $error("skip not settled before fourth phase");

endmodule

// ---- verification/bit_skip_exec_bench.sv ----
module bit_skip_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bit_skip_pkg::*;

  typedef struct packed {
    logic skip;
    file_req_t req;
    logic [7:0] cyc;
    logic [7:0] nops;
  } note_t;

  logic clk, arst_n, instr_valid, ext_set_en, file_rd_en, flush_prefetch;
  logic nop_cycle, busy, skip_taken, exec_done;
  instr_fields_t instr_word;
  logic [BANK_W-1:0] bank_pointer_register;
  file_req_t file_req, req_seen;
  logic [7:0] file_rd_data;
  logic [1:0] next_words;
  logic [PHASES-1:0] phase;
  note_t notes[$];
  note_t n;
  int error_cnt, cmp_count, cyc, nops, fl, tick;

  bit_skip_exec uut (
    .clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_set_en(ext_set_en),
    .bank_pointer_register(bank_pointer_register),
    .file_rd_en(file_rd_en), .file_req(file_req),
    .file_rd_data(file_rd_data), .next_words(next_words),
    .flush_prefetch(flush_prefetch), .nop_cycle(nop_cycle), .busy(busy),
    .skip_taken(skip_taken), .exec_done(exec_done), .phase(phase)
  );

  always #20 clk = ~clk;

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Waits for a free Q1, then presents one instruction and notes the outcome
  task automatic run_instr(input logic [3:0] opc, input logic [2:0] b,
                           input logic a, input logic [7:0] f,
                           input logic [7:0] d, input logic [1:0] nw);
    note_t e;
    logic ext;
    logic [BANK_W-1:0] bp;
    logic [1:0] w;
    ext = 1'($urandom);
    bp = BANK_W'($urandom);
    do @(negedge clk); while (!(phase === 4'h1 && busy === 1'b0));
    instr_valid = 1'b1;
    instr_word = '{opcode: opc, bit_idx: b, bank_sel: a, faddr: f};
    ext_set_en = ext;
    bank_pointer_register = bp;
    e.skip = (opc == OPC_SKIP_SET) ? d[b] : ~d[b];
    if (a) e.req = '{indexed: 1'b0, addr: {bp, f}};
    else if (f <= LIT_OFFSET_MAX)
      e.req = '{indexed: ext, addr: {ACCESS_LO_BANK, f}};
    else e.req = '{indexed: 1'b0, addr: {ACCESS_HI_BANK, f}};
    w = (nw == 2'h0) ? MIN_SKIP_WORDS : nw;
    e.nops = e.skip ? 8'(4 * w) : 8'h00;
    e.cyc = 8'h02 + e.nops;
    notes.push_back(e);
    @(negedge clk);
    file_rd_data = d;
    next_words = nw;
    @(negedge clk);
    // Read data is gone once the read phase is over
    file_rd_data = ~d;
  endtask

  // Result watcher: one note per completed instruction
  always @(posedge clk) begin
    if (file_rd_en) begin
      check("rd_phase", 16'(phase), 16'h0002);
      check("rd_busy", 16'(busy), 16'h0001);
      req_seen = file_req;
      cyc = 0;
      nops = 0;
      fl = 0;
    end else cyc++;
    if (nop_cycle) nops++;
    if (flush_prefetch) begin
      fl++;
      check("flush_phase", 16'(phase), 16'h0008);
    end
    if (exec_done) begin
      if (notes.size() == 0) begin
        check("spurious_done", 16'h0001, 16'h0000);
      end else begin
        n = notes.pop_front();
        check("skip", 16'(skip_taken), 16'(n.skip));
        check("req", 16'(req_seen), 16'(n.req));
        check("cycles", 16'(cyc), 16'(n.cyc));
        check("nops", 16'(nops), 16'(n.nops));
        check("flush", 16'(fl), 16'(n.skip));
        check("done_phase", 16'(phase), 16'h0008);
      end
    end
  end

  // Hang guard, well above 48 instructions of at most 16 clocks
  always @(posedge clk) begin
    tick++;
    if (tick == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    logic [7:0] f, d;
    logic [2:0] b;
    clk = 0; arst_n = 0; instr_valid = 0; ext_set_en = 0;
    instr_word = '0; bank_pointer_register = '0;
    file_rd_data = 8'h00; next_words = 2'h1;
    error_cnt = 0; cmp_count = 0; tick = 0; cyc = 0; nops = 0; fl = 0;
    void'($urandom(32'h393A9277));
    repeat (20) @(negedge clk);
    check("reset_phase", 16'(phase), 16'h0001);
    check("reset_busy", 16'(busy), 16'h0000);
    arst_n = 1;
    // First 16 force a skip over every length, the rest are random
    for (int i = 0; i < 48; i++) begin
      b = 3'($urandom);
      d = 8'($urandom);
      f = (i[5:4] == 2'h0) ? 8'h5F : (i[5:4] == 2'h1) ? 8'h60 : 8'($urandom);
      if (i < 16) d[b] = i[0];
      run_instr(i[0] ? OPC_SKIP_SET : OPC_SKIP_CLR, b, i[3], f, d, i[2:1]);
    end
    // A foreign opcode in a free Q1 must start nothing
    do @(negedge clk); while (!(phase === 4'h1 && busy === 1'b0));
    instr_word.opcode = 4'h8;
    @(negedge clk);
    check("refused_rd", 16'(file_rd_en), 16'h0000);
    check("refused_busy", 16'(busy), 16'h0000);
    instr_valid = 0;
    repeat (8) @(negedge clk);
    check("notes_left", 16'(notes.size()), 16'h0000);
    finish_test();
  end
endmodule
